//--- logic/asb_reg_bank.v
// identification, status, mode and channel-3 registers of the converter
//
// Function
// - identification word at address 0 reads channel count four in bits 11:8.
// - read-only status word at address 1, value 0500h after reset.
// - status bit 15 shows interface lock, zero unlocked after reset.
// - status bit 14 sets on each resynchronization, zero after reset.
// - status bit 13 reads one when the register-map checksum changed.
// - status bit 12 reads one after an input frame checksum error.
// - status bit 11 shows checksum polynomial, zero CCITT, one ANSI.
// - status bit 10 reads one after reset, its power-up value.
// - status bits 9:8 give word length, default 01b for 24 bits.
// - status bits 3:0 flag new data for channels 3 to 0.
// - identification word sits at address zero and is read-only.
// - read-write mode word at address 2, reset value 0510h.
// - mode bit 11 selects one checksum type for all checksum uses.
`timescale 1ns/1ps
`include "asb_regs.vh"
module asb_reg_bank #(
    // identification bits 15:12 and 7:0; values are arbitrary
    parameter [3:0] ID_UPPER_NIBBLE = 4'h5,
    parameter [7:0] ID_LOW_BYTE     = 8'h3c
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // register word port from the serial framer
    input  wire [5:0]  reg_addr,
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    output wire [15:0] reg_rdata,
    output wire        reg_rvalid,
    output wire        reg_addr_err,
    // events and levels from the converter core
    input  wire        if_locked,
    input  wire        resync_pulse,
    input  wire        rx_crc_err_pulse,
    input  wire [15:0] map_crc_value,
    input  wire        map_crc_valid,
    input  wire [3:0]  new_data_pulse,
    input  wire [3:0]  data_taken_pulse,
    // mode settings towards the core
    output wire        map_crc_en,
    output wire        rx_crc_en,
    output wire        crc_type_sel,
    output wire [1:0]  word_length_field,
    output wire        timeout_en,
    output wire [1:0]  drdy_source_sel,
    output wire        drdy_hiz_en,
    output wire        drdy_format,
    // channel 3 settings towards the core
    output wire [9:0]  chan3_phase_delay,
    output wire        chan3_dc_block_disable,
    output wire [1:0]  chan3_input_select,
    output wire [23:0] chan3_offset_calibration,
    output wire [23:0] chan3_gain_calibration,
    // status word as seen by the core
    output wire [15:0] status_word
);

    // stored registers
    reg  [15:0] mode_reg;
    reg  [15:0] mode_next;
    reg  [15:0] channel3_configuration_reg;
    reg  [15:0] ch3_ocal_hi_reg;
    reg  [15:0] ch3_ocal_lo_reg;
    reg  [15:0] ch3_gcal_hi_reg;
    reg  [15:0] ch3_gcal_lo_reg;
    reg         lock_reg;
    reg  [15:0] map_crc_reg;
    reg         map_crc_seen_reg;
    reg  [15:0] status_reg;
    reg  [15:0] status_next;

    // read path
    reg  [15:0] rdata_reg;
    reg  [15:0] rdata_next;
    reg         rvalid_reg;
    reg         addr_err_reg;
    reg         addr_err_next;

    // decoded accesses
    reg         hit_mode;
    reg         hit_cfg;
    reg         hit_ocal_hi;
    reg         hit_ocal_lo;
    reg         hit_gcal_hi;
    reg         hit_gcal_lo;
    reg         mapped;

    // flag plumbing
    wire [`ASB_NUM_FLAGS-1:0] flag_set;
    wire [`ASB_NUM_FLAGS-1:0] flag_clr;
    wire [`ASB_NUM_FLAGS-1:0] flag_q;
    wire [15:0]               id_word;
    wire                      status_read;
    wire                      map_crc_changed;

    localparam [`ASB_NUM_FLAGS-1:0] FLAG_RST = `ASB_FL_RST_VEC;

    // identification is built from constants only; writes are ignored
    assign id_word = {ID_UPPER_NIBBLE, `ASB_ID_CHANCNT, ID_LOW_BYTE};

    // address decode; writes and reads share the same decode
    always @* begin
        hit_mode    = 1'b0;
        hit_cfg     = 1'b0;
        hit_ocal_hi = 1'b0;
        hit_ocal_lo = 1'b0;
        hit_gcal_hi = 1'b0;
        hit_gcal_lo = 1'b0;
        mapped      = 1'b1;
        if (reg_addr == `ASB_ADDR_MODE) begin
            hit_mode = 1'b1;
        end else if (reg_addr == `ASB_ADDR_CHANNEL3_CONFIGURATION) begin
            hit_cfg = 1'b1;
        end else if (reg_addr == `ASB_ADDR_CH3_OCAL_HI) begin
            hit_ocal_hi = 1'b1;
        end else if (reg_addr == `ASB_ADDR_CH3_OCAL_LO) begin
            hit_ocal_lo = 1'b1;
        end else if (reg_addr == `ASB_ADDR_CH3_GCAL_HI) begin
            hit_gcal_hi = 1'b1;
        end else if (reg_addr == `ASB_ADDR_CH3_GCAL_LO) begin
            hit_gcal_lo = 1'b1;
        end else if (reg_addr == `ASB_ADDR_ID ||
                     reg_addr == `ASB_ADDR_STATUS ||
                     reg_addr == `ASB_ADDR_MAP_CRC ||
                     reg_addr == `ASB_ADDR_RSVD_LAST) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // read data mux; reserved word and unmapped addresses read zero
    always @* begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            if (reg_addr == `ASB_ADDR_ID) begin
                rdata_next = id_word;
            end else if (reg_addr == `ASB_ADDR_STATUS) begin
                rdata_next = status_reg;
            end else if (hit_mode) begin
                // bit 10 holds no storage; it shows the reset-occurred flag
                rdata_next = mode_reg;
                rdata_next[`ASB_MD_RESET] = flag_q[`ASB_FL_RESET];
            end else if (hit_cfg) begin
                rdata_next = channel3_configuration_reg;
            end else if (hit_ocal_hi) begin
                rdata_next = ch3_ocal_hi_reg;
            end else if (hit_ocal_lo) begin
                rdata_next = ch3_ocal_lo_reg;
            end else if (hit_gcal_hi) begin
                rdata_next = ch3_gcal_hi_reg;
            end else if (hit_gcal_lo) begin
                rdata_next = ch3_gcal_lo_reg;
            end else if (reg_addr == `ASB_ADDR_MAP_CRC) begin
                rdata_next = map_crc_reg;
            end else begin
                rdata_next = 16'h0000;
            end
        end
    end

    // a write to a read-only word, or any access to a hole, is flagged
    always @* begin
        addr_err_next = 1'b0;
        if ((reg_rd || reg_wr) && !mapped)
            addr_err_next = 1'b1;
        else if (reg_wr && !(hit_mode || hit_cfg || hit_ocal_hi ||
                             hit_ocal_lo || hit_gcal_hi || hit_gcal_lo))
            addr_err_next = 1'b1;
    end

    // mode word; bit 10 is not storage but the reset-occurred flag
    always @* begin
        mode_next = mode_reg;
        if (reg_wr && hit_mode)
            mode_next = reg_wdata & `ASB_MD_WMASK;
        mode_next[`ASB_MD_RESET] = 1'b0;
    end

    assign status_read = reg_rd && (reg_addr == `ASB_ADDR_STATUS);

    // the map checksum only counts as changed while checking is enabled;
    // the first valid value after enabling is taken as the reference
    assign map_crc_changed = map_crc_valid && map_crc_seen_reg &&
                             mode_reg[`ASB_MD_MAP_CRC_EN] &&
                             (map_crc_value != map_crc_reg);

    // sticky flags: new data per channel cleared when the core hands data out, events on a status read, reset flag by a mode write with bit 10 zero
    genvar gi;
    generate
        for (gi = 0; gi < `ASB_NUM_FLAGS; gi = gi + 1) begin : g_flag
            if (gi < 4) begin : g_drdy
                assign flag_set[gi] = new_data_pulse[gi];
                assign flag_clr[gi] = data_taken_pulse[gi];
            end else if (gi == `ASB_FL_RESYNC) begin : g_resync
                assign flag_set[gi] = resync_pulse;
                assign flag_clr[gi] = status_read;
            end else if (gi == `ASB_FL_CRC_ERR) begin : g_crc_err
                // errors only matter while input checking is on
                assign flag_set[gi] = rx_crc_err_pulse &&
                                      mode_reg[`ASB_MD_RX_CRC_EN];
                assign flag_clr[gi] = status_read;
            end else if (gi == `ASB_FL_MAP_CHG) begin : g_map
                assign flag_set[gi] = map_crc_changed;
                assign flag_clr[gi] = status_read;
            end else begin : g_reset
                // only the reset itself sets this flag
                assign flag_set[gi] = 1'b0;
                assign flag_clr[gi] = reg_wr && hit_mode &&
                                      !reg_wdata[`ASB_MD_RESET];
            end
            asb_sticky_flag #(
                .RST_VAL (FLAG_RST[gi])
            ) u_flag (
                .ref_clk   (ref_clk),
                .rstn      (rstn),
                .set_pulse (flag_set[gi]),
                .clr_pulse (flag_clr[gi]),
                .flag      (flag_q[gi])
            );
        end
    endgenerate

    // status word; type and length follow the mode word
    always @* begin
        status_next = 16'h0000;
        status_next[`ASB_ST_LOCK]     = lock_reg;
        status_next[`ASB_ST_RESYNC]   = flag_q[`ASB_FL_RESYNC];
        status_next[`ASB_ST_MAP_CHG]  = flag_q[`ASB_FL_MAP_CHG];
        status_next[`ASB_ST_CRC_ERR]  = flag_q[`ASB_FL_CRC_ERR];
        status_next[`ASB_ST_CRC_TYPE] = mode_reg[`ASB_MD_CRC_TYPE];
        status_next[`ASB_ST_RESET]    = flag_q[`ASB_FL_RESET];
        status_next[`ASB_ST_WLEN_MSB:`ASB_ST_WLEN_LSB] =
            mode_reg[`ASB_MD_WLEN_MSB:`ASB_MD_WLEN_LSB];
        status_next[3:0] = flag_q[3:0];
    end

    // status is registered one cycle behind its sources so that the
    // value read and the value driven to the core always agree
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= `ASB_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // stored words
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg        <= `ASB_RST_MODE & `ASB_MD_WMASK;
            channel3_configuration_reg     <= `ASB_RST_CHANNEL3_CONFIGURATION;
            ch3_ocal_hi_reg <= `ASB_RST_CH3_OCAL_HI;
            ch3_ocal_lo_reg <= `ASB_RST_CH3_OCAL_LO;
            ch3_gcal_hi_reg <= `ASB_RST_CH3_GCAL_HI;
            ch3_gcal_lo_reg <= `ASB_RST_CH3_GCAL_LO;
        end else begin
            mode_reg <= mode_next;
            if (reg_wr && hit_cfg)
                channel3_configuration_reg <= reg_wdata & `ASB_CHANNEL3_CONFIGURATION_WMASK;
            if (reg_wr && hit_ocal_hi)
                ch3_ocal_hi_reg <= reg_wdata;
            if (reg_wr && hit_ocal_lo)
                ch3_ocal_lo_reg <= reg_wdata & `ASB_CAL_LO_WMASK;
            if (reg_wr && hit_gcal_hi)
                ch3_gcal_hi_reg <= reg_wdata;
            if (reg_wr && hit_gcal_lo)
                ch3_gcal_lo_reg <= reg_wdata & `ASB_CAL_LO_WMASK;
        end
    end

    // core levels and checksum reference
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lock_reg         <= 1'b0;
            map_crc_reg      <= 16'h0000;
            map_crc_seen_reg <= 1'b0;
        end else begin
            lock_reg <= if_locked;
            if (!mode_reg[`ASB_MD_MAP_CRC_EN]) begin
                map_crc_seen_reg <= 1'b0;
            end else if (map_crc_valid) begin
                map_crc_reg      <= map_crc_value;
                map_crc_seen_reg <= 1'b1;
            end
        end
    end

    // read answer one cycle after the request
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg    <= 16'h0000;
            rvalid_reg   <= 1'b0;
            addr_err_reg <= 1'b0;
        end else begin
            rdata_reg    <= rdata_next;
            rvalid_reg   <= reg_rd;
            addr_err_reg <= addr_err_next;
        end
    end

    // outputs, all from flip-flops
    assign reg_rdata    = rdata_reg;
    assign reg_rvalid   = rvalid_reg;
    assign reg_addr_err = addr_err_reg;

    // one checksum type governs input, output and map checking
    assign crc_type_sel      = mode_reg[`ASB_MD_CRC_TYPE];
    assign map_crc_en        = mode_reg[`ASB_MD_MAP_CRC_EN];
    assign rx_crc_en         = mode_reg[`ASB_MD_RX_CRC_EN];
    assign word_length_field = mode_reg[`ASB_MD_WLEN_MSB:`ASB_MD_WLEN_LSB];
    assign timeout_en        = mode_reg[`ASB_MD_TIMEOUT];
    assign drdy_source_sel   = mode_reg[`ASB_MD_DRSEL_MSB:`ASB_MD_DRSEL_LSB];
    assign drdy_hiz_en       = mode_reg[`ASB_MD_DR_HIZ];
    assign drdy_format       = mode_reg[`ASB_MD_DR_FMT];

    assign chan3_phase_delay        = channel3_configuration_reg[15:6];
    assign chan3_dc_block_disable   = channel3_configuration_reg[2];
    assign chan3_input_select       = channel3_configuration_reg[1:0];
    assign chan3_offset_calibration = {ch3_ocal_hi_reg, ch3_ocal_lo_reg[15:8]};
    assign chan3_gain_calibration   = {ch3_gcal_hi_reg, ch3_gcal_lo_reg[15:8]};

    assign status_word = status_reg;

endmodule // asb_reg_bank

//--- common/asb_regs.vh
// register offsets, field positions and reset values of the status bank
`ifndef ASB_REGS_VH
`define ASB_REGS_VH

// word addresses
`define ASB_ADDR_ID          6'h00
`define ASB_ADDR_STATUS      6'h01
`define ASB_ADDR_MODE        6'h02
`define ASB_ADDR_CHANNEL3_CONFIGURATION     6'h18
`define ASB_ADDR_CH3_OCAL_HI 6'h19
`define ASB_ADDR_CH3_OCAL_LO 6'h1a
`define ASB_ADDR_CH3_GCAL_HI 6'h1b
`define ASB_ADDR_CH3_GCAL_LO 6'h1c
`define ASB_ADDR_MAP_CRC     6'h3e
`define ASB_ADDR_RSVD_LAST   6'h3f

// reset values
`define ASB_RST_STATUS       16'h0500
`define ASB_RST_MODE         16'h0510
`define ASB_RST_CHANNEL3_CONFIGURATION      16'h0000
`define ASB_RST_CH3_OCAL_HI  16'h0000
`define ASB_RST_CH3_OCAL_LO  16'h0000
`define ASB_RST_CH3_GCAL_HI  16'h8000
`define ASB_RST_CH3_GCAL_LO  16'h0000

// identification word
`define ASB_ID_CHANCNT_MSB   11
`define ASB_ID_CHANCNT_LSB   8
`define ASB_ID_CHANCNT       4'h4

// status word bit positions
`define ASB_ST_LOCK          15
`define ASB_ST_RESYNC        14
`define ASB_ST_MAP_CHG       13
`define ASB_ST_CRC_ERR       12
`define ASB_ST_CRC_TYPE      11
`define ASB_ST_RESET         10
`define ASB_ST_WLEN_MSB      9
`define ASB_ST_WLEN_LSB      8

// mode word bit positions
`define ASB_MD_MAP_CRC_EN    13
`define ASB_MD_RX_CRC_EN     12
`define ASB_MD_CRC_TYPE      11
`define ASB_MD_RESET         10
`define ASB_MD_WLEN_MSB      9
`define ASB_MD_WLEN_LSB      8
`define ASB_MD_TIMEOUT       4
`define ASB_MD_DRSEL_MSB     3
`define ASB_MD_DRSEL_LSB     2
`define ASB_MD_DR_HIZ        1
`define ASB_MD_DR_FMT        0
// bits of the mode word that hold storage, plus bit 10; reserved bits stay zero
`define ASB_MD_WMASK         16'h3f1f

// writable bits of the channel-3 words
`define ASB_CHANNEL3_CONFIGURATION_WMASK    16'hffc7
`define ASB_CAL_LO_WMASK     16'hff00

// sticky flag indices
`define ASB_FL_CHAN0_NEW_DATA_FLAG         0
`define ASB_FL_RESYNC        4
`define ASB_FL_CRC_ERR       5
`define ASB_FL_MAP_CHG       6
`define ASB_FL_RESET         7
`define ASB_NUM_FLAGS        8
// reset values of the flags, index 7 (reset occurred) comes up set
`define ASB_FL_RST_VEC       8'h80

`endif

//--- logic/asb_sticky_flag.v
// one sticky status flag: set by a set pulse, cleared by a clear pulse, set wins
`timescale 1ns/1ps
module asb_sticky_flag #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input  wire ref_clk,
    input  wire rstn,
    // control
    input  wire set_pulse,
    input  wire clr_pulse,
    // state
    output wire flag
);

    reg flag_reg;
    reg flag_next;

    // an event arriving in the clearing cycle must not be lost
    always @* begin
        flag_next = flag_reg;
        if (clr_pulse)
            flag_next = 1'b0;
        if (set_pulse)
            flag_next = 1'b1;
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            flag_reg <= RST_VAL;
        else
            flag_reg <= flag_next;
    end

    assign flag = flag_reg;

endmodule // asb_sticky_flag

//--- testbench/asb_reg_bank_properties.sv
// concurrent checks on the ports of the status register bank
`timescale 1ns/1ps
module asb_reg_bank_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // register port
    input wire logic [5:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    // converter events
    input wire logic        if_locked,
    input wire logic        resync_pulse,
    input wire logic [3:0]  new_data_pulse,
    input wire logic [3:0]  data_taken_pulse,
    // mode and status
    input wire logic        crc_type_sel,
    input wire logic [1:0]  word_length_field,
    input wire logic [15:0] status_word
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    id_count_a: assert property (reg_rd && reg_addr == 6'h00
        |=> reg_rdata[11:8] == 4'h4)
        else $error("channel count wrong");
    status_read_a: assert property (reg_rd && reg_addr == 6'h01
        |=> reg_rdata == $past(status_word))
        else $error("status readback differs");
    lock_follow_a: assert property (
        status_word[15] == $past(if_locked, 2))
        else $error("lock bit not following lock level");
    resync_set_a: assert property (
        resync_pulse |-> ##2 status_word[14])
        else $error("resync flag not set");
    type_mirror_a: assert property (
        status_word[11] == $past(crc_type_sel))
        else $error("checksum type not mirrored");
    length_mirror_a: assert property (
        status_word[9:8] == $past(word_length_field))
        else $error("word length not mirrored");
    new_data_a: assert property (
        new_data_pulse[0] |-> ##2 status_word[0])
        else $error("new data flag not set");
    data_clear_a: assert property ($fell(status_word[3])
        |-> $past(data_taken_pulse[3], 2))
        else $error("new data flag dropped without take");
    reset_flag_a: assert property (!$rose(status_word[10]))
        else $error("reset flag rose outside reset");
    reserved_zero_a: assert property (status_word[7:4] == 4'h0)
        else $error("status reserved bits not zero");

    cover property (resync_pulse ##2 status_word[14]);
    cover property (reg_rd && reg_addr == 6'h01 ##1 reg_rdata[15]);
    cover property ($fell(status_word[10]));
endmodule // asb_reg_bank_props

bind asb_reg_bank asb_reg_bank_props u_props (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .if_locked(if_locked), .resync_pulse(resync_pulse),
    .new_data_pulse(new_data_pulse),
    .data_taken_pulse(data_taken_pulse), .crc_type_sel(crc_type_sel),
    .word_length_field(word_length_field), .status_word(status_word)
);

//--- testbench/asb_host_model.sv
// host model issuing word reads and writes to the status bank
`timescale 1ns/1ps
module asb_host_model (
    // clock
    input  wire logic        ref_clk,
    // request
    output logic [5:0]  reg_addr,
    output logic        reg_rd,
    output logic        reg_wr,
    output logic [15:0] reg_wdata,
    // answer
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_addr  = 6'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // idle lines show the inverse so a stale value never looks valid
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] d,
                      output logic ok);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        ok       = reg_rvalid;
        d        = reg_rdata;
    endtask
endmodule // asb_host_model

//--- testbench/tb.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
module tb;
    logic        ref_clk, rstn, if_locked, resync_pulse, rx_crc_err_pulse;
    logic        map_crc_valid, reg_rd, reg_wr, reg_rvalid, crc_type_sel;
    logic [3:0]  new_data_pulse, data_taken_pulse;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, map_crc_value;
    logic [1:0]  wlen, dsel, mux;
    logic        aerr, map_en, rx_en, tmo, hiz, fmt, dcb;
    logic [9:0]  ph;
    logic [23:0] ocal, gcal;
    int          fails, n_compared;
    logic [5:0]  ra [7] = '{6'h00, 6'h01, 6'h02, 6'h1b, 6'h3e, 6'h3f, 6'h20};
    logic [15:0] rm [7] = '{16'h0f00, 16'hffff, 16'hffff, 16'hffff,
                            16'hffff, 16'hffff, 16'hffff};
    logic [15:0] re [7] = '{16'h0400, 16'h0500, 16'h0510, 16'h8000,
                            16'h0000, 16'h0000, 16'h0000};

    always #2.5 ref_clk = ~ref_clk;

    asb_host_model host (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    asb_reg_bank DUT (
        .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr_err(aerr),
        .if_locked(if_locked), .resync_pulse(resync_pulse),
        .rx_crc_err_pulse(rx_crc_err_pulse),
        .map_crc_value(map_crc_value), .map_crc_valid(map_crc_valid),
        .new_data_pulse(new_data_pulse),
        .data_taken_pulse(data_taken_pulse), .map_crc_en(map_en),
        .rx_crc_en(rx_en), .crc_type_sel(crc_type_sel),
        .word_length_field(wlen), .timeout_en(tmo),
        .drdy_source_sel(dsel), .drdy_hiz_en(hiz), .drdy_format(fmt),
        .chan3_phase_delay(ph), .chan3_dc_block_disable(dcb),
        .chan3_input_select(mux), .chan3_offset_calibration(ocal),
        .chan3_gain_calibration(gcal), .status_word()
    );

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [15:0] m,
                          input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        host.rd(a, d, ok);
        chk($sformatf("rvalid %h", a), 16'h0001, {15'h0, ok});
        chk($sformatf("word %h", a), e, d & m);
    endtask

    task automatic do_reset;
        rstn = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // the whole sequence needs under a hundred cycles
    initial begin
        #(5000 * 5);
        fails++;
        final_report;
    end

    initial begin
        ref_clk = 1'b0;
        {if_locked, resync_pulse, rx_crc_err_pulse, map_crc_valid} = 4'h0;
        {new_data_pulse, data_taken_pulse} = 8'h00;
        map_crc_value = 16'h0000;
        do_reset;
        for (int i = 0; i < 7; i++)
            rd_chk(ra[i], rm[i], re[i]);
        chk("mode outs", 16'h0030,
            {7'h0, map_en, rx_en, wlen, tmo, dsel, hiz, fmt});
        chk("gain cal", 16'h8000, gcal[23:8]);
        $display("test reset_values done");
        host.wr(6'h00, 16'h0000);
        chk("addr err", 16'h0001, {15'h0, aerr});
        host.wr(6'h01, 16'hffff);
        chk("addr err", 16'h0001, {15'h0, aerr});
        rd_chk(6'h01, 16'hffff, 16'h0500);
        rd_chk(6'h00, 16'h0f00, 16'h0400);
        $display("test read_only done");
        host.wr(6'h18, 16'hffff);
        host.wr(6'h19, 16'h1234);
        host.wr(6'h1a, 16'h56ff);
        host.wr(6'h1c, 16'hab12);
        rd_chk(6'h18, 16'hffff, 16'hffc7);
        rd_chk(6'h1a, 16'hffff, 16'h5600);
        chk("channel3_configuration outs", 16'h1fff, {3'h0, ph, dcb, mux});
        chk("offset cal", 16'h1234, ocal[23:8]);
        chk("offset cal lo", 16'h0056, {8'h00, ocal[7:0]});
        chk("gain cal lo", 16'h00ab, {8'h00, gcal[7:0]});
        $display("test channel3 done");
        for (int i = 0; i < 4; i++) begin
            host.wr(6'h02, {4'h0, i[0], 1'b0, i[1:0], 8'h10});
            chk("addr err", 16'h0000, {15'h0, aerr});
            rd_chk(6'h01, 16'hffff,
                   {4'h0, i[0], 1'b0, i[1:0], 8'h00});
            rd_chk(6'h02, 16'hffff,
                   {4'h0, i[0], 1'b0, i[1:0], 8'h10});
            chk("type select", {15'h0, i[0]}, {15'h0, crc_type_sel});
        end
        $display("test mode_mirror done");
        host.wr(6'h02, 16'h3010);
        chk("mode outs", 16'h0190,
            {7'h0, map_en, rx_en, wlen, tmo, dsel, hiz, fmt});
        @(posedge ref_clk);
        #1;
        {if_locked, resync_pulse, rx_crc_err_pulse} = 3'h7;
        {new_data_pulse, map_crc_valid, map_crc_value} = {5'h1f, 16'h1234};
        @(posedge ref_clk);
        #1;
        {resync_pulse, rx_crc_err_pulse, new_data_pulse} = 6'h00;
        map_crc_value = 16'h4321;
        @(posedge ref_clk);
        #1;
        map_crc_valid = 1'b0;
        repeat (3) @(posedge ref_clk);
        rd_chk(6'h01, 16'hffff, 16'hf00f);
        rd_chk(6'h01, 16'hffff, 16'h800f);
        @(posedge ref_clk);
        #1;
        data_taken_pulse = 4'h9;
        @(posedge ref_clk);
        #1;
        data_taken_pulse = 4'h0;
        repeat (2) @(posedge ref_clk);
        rd_chk(6'h01, 16'hffff, 16'h8006);
        $display("test status_events done");
        if_locked = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        do_reset;
        rd_chk(6'h01, 16'hffff, 16'h0500);
        rd_chk(6'h02, 16'hffff, 16'h0510);
        $display("test second_reset done");
        final_report;
    end
endmodule // tb
